// [logic/pot_cmd_consts.vh]
`ifndef POT_CMD_CONSTS_VH
`define POT_CMD_CONSTS_VH
// ----------------------------------------
// Address and opcodes
// ----------------------------------------
`define ADDR_FIXED 4'h5
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'ha
`define OP_RD_SLOT 4'hb
`define OP_WR_SLOT 4'hc
`define OP_SLOT_TO_WIPER 4'hd
`define OP_WIPER_TO_SLOT 4'he
`define OP_GLB_SLOT_TO_WIPER 4'h1
`define OP_GLB_WIPER_TO_SLOT 4'h8
`define OP_STEP 4'h2
// ----------------------------------------
// Widths, reset values, timing
// ----------------------------------------
`define WIPER_W 6
`define TAP_COUNT 64
`define WIPER_RST 6'h00
`define WIPER_MAX 6'h3f
`define NV_WRITE_MS 5
`define CLK_MHZ 125
`define NV_WRITE_CYC (`NV_WRITE_MS * 1000 * `CLK_MHZ)
`endif

// [logic/pot_cmd_frames.v]
`timescale 1ns/1ps
`include "pot_cmd_consts.vh"
module pot_cmd_frames #(
  parameter NV_WRITE_CYCLES = `NV_WRITE_CYC
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [3:0] chip_select_pins,
  output reg [`TAP_COUNT-1:0] tap_sel0,
  output reg [`TAP_COUNT-1:0] tap_sel1,
  output reg nv_busy
);
  // ----------------------------------------
  // Frame states, one-hot
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_INSTR = 6'h04;
  localparam [5:0] ST_WDATA = 6'h08;
  localparam [5:0] ST_RDATA = 6'h10;
  localparam [5:0] ST_STEP = 6'h20;
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  reg scl_s1_r, scl_s2_r, scl_d_r;  // Two flops then history
  reg sda_s1_r, sda_s2_r, sda_d_r;
  always @(posedge core_clk) begin
    if (!reset_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (clk_en) begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  // Start/stop only while the clock line is high
  wire start_seen = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_seen = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  // ----------------------------------------
  // Storage: two wipers, four slots per pot
  // ----------------------------------------
  reg [5:0] state_r;
  reg [3:0] bit_cnt_r;  // 0..9, 8 is the ack slot, 9 ends a read
  reg [7:0] shift_r;
  reg [3:0] op_r;  // Latched opcode
  reg pot_select_bit;
  reg slot_select_hi, slot_select_lo;
  reg ack_phase_r;  // Device owns the ack bit
  reg step_dir_r;  // Direction sampled on the step pulse rise
  reg nv_pend_r;  // Programming armed, waits for STOP
  reg [`WIPER_W-1:0] nv_data_r [0:1];  // Captured data per pot
  reg [1:0] nv_mask_r;  // Which pots get written
  reg [1:0] nv_slot_r;  // Target slot, held apart from later frames
  reg [31:0] nv_cnt_r;
  reg [`WIPER_W-1:0] wiper_position_reg [0:1];
  reg [`WIPER_W-1:0] stored_setting_slot [0:7];  // Index {pot,slot}
  wire [1:0] slot_idx = {slot_select_hi, slot_select_lo};
  wire [2:0] sel_idx = {pot_select_bit, slot_idx};
  wire [`WIPER_W-1:0] cur_wiper = wiper_position_reg[pot_select_bit];
  // Read byte: two zero bits above the six-bit value
  wire [7:0] rd_byte = {2'b00, (op_r == `OP_RD_WIPER) ? cur_wiper :
                        stored_setting_slot[sel_idx]};
  wire addr_match = (shift_r[7:4] == `ADDR_FIXED) &&
                    (shift_r[3:0] == chip_select_pins);
  integer i;
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      op_r <= 4'h0;
      pot_select_bit <= 1'b0;
      slot_select_hi <= 1'b0;
      slot_select_lo <= 1'b0;
      ack_phase_r <= 1'b0;
      step_dir_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      nv_pend_r <= 1'b0;
      nv_mask_r <= 2'h0;
      nv_slot_r <= 2'h0;
      nv_cnt_r <= 32'h0;
      nv_busy <= 1'b0;
      tap_sel0 <= {`TAP_COUNT{1'b0}};
      tap_sel1 <= {`TAP_COUNT{1'b0}};
      nv_data_r[0] <= `WIPER_RST;
      nv_data_r[1] <= `WIPER_RST;
      wiper_position_reg[0] <= `WIPER_RST;
      wiper_position_reg[1] <= `WIPER_RST;
      for (i = 0; i < 8; i = i + 1) begin
        stored_setting_slot[i] <= `WIPER_RST;
      end
    end else if (clk_en) begin
      // Programming timer; slots land at the end of the window
      if (nv_busy) begin
        if (nv_cnt_r == 32'h1) begin
          nv_busy <= 1'b0;
          if (nv_mask_r[0]) stored_setting_slot[{1'b0, nv_slot_r}] <= nv_data_r[0];
          if (nv_mask_r[1]) stored_setting_slot[{1'b1, nv_slot_r}] <= nv_data_r[1];
        end
        nv_cnt_r <= nv_cnt_r - 32'h1;
      end
      if (stop_seen) begin
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
        if (nv_pend_r) begin
          nv_pend_r <= 1'b0;
          nv_busy <= 1'b1;
          nv_cnt_r <= NV_WRITE_CYCLES;
        end
      end else if (start_seen) begin
        // Repeated start drops any pending programming
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe <= 1'b0;
        ack_phase_r <= 1'b0;
        nv_pend_r <= 1'b0;
      end else if (scl_rise && !ack_phase_r && state_r != ST_IDLE &&
                   state_r != ST_RDATA) begin
        if (state_r == ST_STEP) begin
          // Direction only; the move waits for the pulse to end, so the
          // clock pulse of a STOP never moves the wiper
          step_dir_r <= sda_s2_r;
        end else begin
          shift_r <= {shift_r[6:0], sda_s2_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_phase_r) begin
          // Ack bit done, release and move on
          ack_phase_r <= 1'b0;
          sda_oe <= 1'b0;
          bit_cnt_r <= 4'h0;
          if (state_r == ST_RDATA) begin
            // First data bit goes out on the fall that ends the ack
            sda_out <= rd_byte[7];
            shift_r <= {rd_byte[6:0], 1'b0};
            bit_cnt_r <= 4'h1;
            sda_oe <= 1'b1;
          end
        end else if (state_r == ST_STEP) begin
          // Pulse complete: move one tap, pinned at both ends
          if (step_dir_r && cur_wiper != `WIPER_MAX)
            wiper_position_reg[pot_select_bit] <= cur_wiper + 6'h01;
          else if (!step_dir_r && cur_wiper != `WIPER_RST)
            wiper_position_reg[pot_select_bit] <= cur_wiper - 6'h01;
        end else if (state_r == ST_RDATA) begin
          if (bit_cnt_r == 4'h8) begin
            sda_oe <= 1'b0;  // Released for the master's no-ack bit; STOP follows
            bit_cnt_r <= 4'h9;
          end else if (bit_cnt_r < 4'h8) begin
            sda_out <= shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end else if (bit_cnt_r == 4'h8) begin
          bit_cnt_r <= 4'h0;
          case (state_r)
            ST_ADDR: begin
              if (addr_match) begin
                ack_phase_r <= 1'b1;
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
                state_r <= ST_INSTR;
              end else begin
                state_r <= ST_IDLE;  // Not ours, stay silent
              end
            end
            ST_INSTR: begin
              op_r <= shift_r[7:4];
              pot_select_bit <= shift_r[2];
              slot_select_hi <= shift_r[1];
              slot_select_lo <= shift_r[0];
              ack_phase_r <= 1'b1;
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_r <= ST_IDLE;
              case (shift_r[7:4])
                `OP_RD_WIPER, `OP_RD_SLOT: state_r <= ST_RDATA;
                `OP_WR_WIPER, `OP_WR_SLOT: state_r <= ST_WDATA;
                `OP_STEP: state_r <= ST_STEP;
                `OP_GLB_SLOT_TO_WIPER: begin
                  wiper_position_reg[0] <= stored_setting_slot[{1'b0, shift_r[1:0]}];
                  wiper_position_reg[1] <= stored_setting_slot[{1'b1, shift_r[1:0]}];
                end
                `OP_SLOT_TO_WIPER:
                  wiper_position_reg[shift_r[2]] <= stored_setting_slot[shift_r[2:0]];
                `OP_GLB_WIPER_TO_SLOT: begin
                  // Busy: acked but dropped, in-flight data stays intact
                  if (!nv_busy) begin
                    nv_data_r[0] <= wiper_position_reg[0];
                    nv_data_r[1] <= wiper_position_reg[1];
                    nv_mask_r <= 2'b11;
                    nv_slot_r <= shift_r[1:0];
                    nv_pend_r <= 1'b1;
                  end
                end
                `OP_WIPER_TO_SLOT: begin
                  if (!nv_busy) begin
                    nv_data_r[shift_r[2]] <= wiper_position_reg[shift_r[2]];
                    nv_mask_r <= shift_r[2] ? 2'b10 : 2'b01;
                    nv_slot_r <= shift_r[1:0];
                    nv_pend_r <= 1'b1;
                  end
                end
                default: begin
                  ack_phase_r <= 1'b0;  // Unknown opcode: no ack
                  sda_oe <= 1'b0;
                end
              endcase
            end
            ST_WDATA: begin
              ack_phase_r <= 1'b1;
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_r <= ST_IDLE;
              if (op_r == `OP_WR_WIPER) begin
                wiper_position_reg[pot_select_bit] <= shift_r[5:0];
              end else if (!nv_busy) begin
                nv_data_r[pot_select_bit] <= shift_r[5:0];
                nv_mask_r <= pot_select_bit ? 2'b10 : 2'b01;
                nv_slot_r <= slot_idx;
                nv_pend_r <= 1'b1;
              end
            end
            default: state_r <= ST_IDLE;
          endcase
        end
      end
      // Tap decoders: exactly one switch closed per pot after the first enabled clock; reset opens all
      tap_sel0 <= {{(`TAP_COUNT-1){1'b0}}, 1'b1} << wiper_position_reg[0];
      tap_sel1 <= {{(`TAP_COUNT-1){1'b0}}, 1'b1} << wiper_position_reg[1];
    end
  end
endmodule

// [tb/pot_cmd_frames_sva.sv]
`timescale 1ns/1ps
// ------
// Pin checker
// ------
module pot_cmd_frames_sva #(parameter NV_WRITE_CYCLES = 625000) (
  input wire core_clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [3:0] chip_select_pins,
  input wire [63:0] tap_sel0,
  input wire [63:0] tap_sel1,
  input wire nv_busy
);
  reg scl_r, sda_r, idle_r, bad_r;
  reg [3:0] nbit_r, age_r;
  reg [7:0] addr_r;
  reg [19:0] busy_r;
  wire start_w = scl_in && scl_r && sda_r && !sda_in;
  wire stop_w = scl_in && scl_r && !sda_r && sda_in;
  // Frame tracker on raw pins; age counts cycles since STOP
  always @(posedge core_clk) begin
    scl_r <= scl_in;
    sda_r <= sda_in;
    busy_r <= nv_busy ? busy_r + 20'h1 : 20'h0;
    age_r <= !reset_n ? 4'hf : stop_w ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    if (!reset_n || start_w) begin
      idle_r <= 1'b0;
      bad_r <= 1'b0;
      nbit_r <= reset_n ? 4'h0 : 4'h9;
    end else if (stop_w) begin
      idle_r <= 1'b1;
    end else if (scl_in && !scl_r && nbit_r < 4'h8) begin
      addr_r <= {addr_r[6:0], sda_in};
      nbit_r <= nbit_r + 4'h1;
    end else if (nbit_r == 4'h8 && addr_r != {4'h5, chip_select_pins}) begin
      bad_r <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  tap0_onehot_a: assert property ($past(reset_n) |-> $onehot(tap_sel0))
    else $error("tap_sel0 not one-hot");
  tap1_onehot_a: assert property ($past(reset_n) |-> $onehot(tap_sel1))
    else $error("tap_sel1 not one-hot");
  busy_after_stop_a: assert property ($rose(nv_busy) |-> age_r < 4'h8)
    else $error("programming began without STOP");
  busy_bound_a: assert property (busy_r <= NV_WRITE_CYCLES)
    else $error("programming too long");
  bad_addr_quiet_a: assert property (bad_r |-> !sda_oe)
    else $error("drove bus for other address");
  idle_quiet_a: assert property (idle_r && $past(idle_r, 4) |-> !sda_oe)
    else $error("drove idle bus");
  idle_taps_a: assert property (idle_r && $past(idle_r, 4) |->
    $stable(tap_sel0) && $stable(tap_sel1))
    else $error("wiper moved on idle bus");
  data_hold_a: assert property (scl_in && $past(scl_in, 2) |->
    $stable(sda_out) && $stable(sda_oe))
    else $error("data changed while clock high");
endmodule
bind pot_cmd_frames pot_cmd_frames_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_sva (
  .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
  .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy));

// [tb/bus_master_model.sv]
`timescale 1ns/1ps
// Bus master; pulls low or releases, SCL idles high between frames
module bus_master_model (
  input wire core_clk,
  input wire sda_line,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // One 64 ns cell; sample late in high phase to clear the slow turn-around
  task automatic bit_cell(input logic b, output logic r);
    scl = 1'b0;
    repeat (2) @(negedge core_clk);
    sda_m = b;
    repeat (2) @(negedge core_clk);
    scl = 1'b1;
    repeat (3) @(negedge core_clk);
    r = sda_line;
    @(negedge core_clk);
  endtask
  task automatic start();
    sda_m = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic stop();
    scl = 1'b0;
    repeat (2) @(negedge core_clk);
    sda_m = 1'b0;
    repeat (2) @(negedge core_clk);
    scl = 1'b1;
    repeat (4) @(negedge core_clk);
    sda_m = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  // Byte out, MSB first, ninth cell released for acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(d[i], r);
    bit_cell(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then no acknowledge so STOP may follow
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(1'b1, d[i]);
    bit_cell(1'b1, r);
  endtask
endmodule

// [tb/pot_cmd_frames_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module pot_cmd_frames_test;
  logic core_clk, reset_n, clk_en, scl, sda_m, sda_oe, sda_out, nv_busy, ack;
  logic [3:0] pins;
  logic [63:0] tap_sel0, tap_sel1;
  logic [7:0] rd_d;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // Open-drain line with pull-up
  wire sda_line = !(sda_m == 1'b0 || (sda_oe && !sda_out));
  pot_cmd_frames #(.NV_WRITE_CYCLES(50)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_pins(pins), .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy));
  bus_master_model u_m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic open(input logic [7:0] ins);
    u_m.start();
    u_m.wbyte({4'h5, pins}, ack);
    `CHK("addr ack", 1'b1, ack)
    u_m.wbyte(ins, ack);
    `CHK("instr ack", 1'b1, ack)
  endtask
  task automatic cmd(input logic [7:0] ins, input logic has_d, input logic [7:0] d);
    open(ins);
    if (has_d) begin
      u_m.wbyte(d, ack);
      `CHK("data ack", 1'b1, ack)
    end
    u_m.stop();
  endtask
  task automatic rd(input logic [7:0] ins, input logic [7:0] e);
    open(ins);
    u_m.rbyte(rd_d);
    u_m.stop();
    `CHK("read", e, rd_d)
  endtask
  // Programming must start after STOP and end in bounded time
  task automatic nv_wait();
    repeat (2) @(negedge core_clk);
    `CHK("nv busy", 1'b1, nv_busy)
    repeat (60) if (nv_busy) @(negedge core_clk);
    `CHK("nv done", 1'b0, nv_busy)
  endtask
  task automatic step_chk(input logic p, input logic [5:0] w0, input logic dir,
                          input logic [5:0] w1);
    logic r;
    cmd({4'ha, 1'b0, p, 2'b00}, 1'b1, {2'b00, w0});
    open({4'h2, 1'b0, p, 2'b00});
    repeat (3) u_m.bit_cell(dir, r);
    // Third step lands on the STOP's falling clock edge
    u_m.stop();
    `CHK("step", 64'h1 << w1, (p ? tap_sel1 : tap_sel0))
  endtask
  initial begin
    reset_n = 1'b0;
    pins = 4'h6;
    clk_en = 1'b1;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("tap0 reset", 64'h1, tap_sel0)
    u_m.start();
    u_m.wbyte({4'h5, ~pins}, ack);
    `CHK("foreign addr", 1'b0, ack)
    u_m.stop();
    cmd(8'ha0, 1'b1, 8'h2a);
    cmd(8'ha4, 1'b1, 8'h15);
    `CHK("tap0", 64'h1 << 42, tap_sel0)
    `CHK("tap1", 64'h1 << 21, tap_sel1)
    rd(8'h90, 8'h2a);
    rd(8'h94, 8'h15);
    // Frozen block must ignore a whole frame
    clk_en = 1'b0;
    u_m.start();
    u_m.wbyte({4'h5, pins}, ack);
    `CHK("frozen ack", 1'b0, ack)
    u_m.stop();
    clk_en = 1'b1;
    // Undefined opcode gets no acknowledge
    u_m.start();
    u_m.wbyte({4'h5, pins}, ack);
    u_m.wbyte(8'h40, ack);
    `CHK("bad opcode", 1'b0, ack)
    u_m.stop();
    `CHK("tap0 kept", 64'h1 << 42, tap_sel0)
    $display("wiper test done");
    for (int s = 0; s < 4; s++) begin
      cmd({6'h30, s[1:0]}, 1'b1, {6'h0c, s[1:0]});
      nv_wait();
      rd({6'h2c, s[1:0]}, {6'h0c, s[1:0]});
    end
    $display("slot test done");
    cmd(8'hd2, 1'b0, 8'h00);
    `CHK("slot to wiper", 64'h1 << 50, tap_sel0)
    cmd(8'he5, 1'b0, 8'h00);
    nv_wait();
    rd(8'hb5, 8'h15);
    cmd(8'h83, 1'b0, 8'h00);
    nv_wait();
    rd(8'hb3, 8'h32);
    rd(8'hb7, 8'h15);
    cmd(8'ha0, 1'b1, 8'h01);
    cmd(8'ha4, 1'b1, 8'h02);
    cmd(8'h13, 1'b0, 8'h00);
    `CHK("global tap0", 64'h1 << 50, tap_sel0)
    `CHK("global tap1", 64'h1 << 21, tap_sel1)
    $display("transfer test done");
    step_chk(1'b0, 6'h02, 1'b0, 6'h00);
    step_chk(1'b1, 6'h3d, 1'b1, 6'h3f);
    step_chk(1'b0, 6'h10, 1'b1, 6'h13);
    step_chk(1'b1, 6'h10, 1'b0, 6'h0d);
    $display("step test done");
    finish_test();
  end
endmodule
